//--- verilog/src_pkg.sv
/*
  Package for the system reset controller: register offsets, cause bits,
  target bits, reset values and timing constants.
  Assumes a 100 MHz pclk and APB with 32-bit data.
*/
package src_pkg;
  // Register byte offsets
  localparam logic [11:0] SRC_OFF_CAUSE = 12'h000;
  localparam logic [11:0] SRC_OFF_MASK = 12'h004;
  localparam logic [11:0] SRC_OFF_STATUS = 12'h008;
  localparam logic [11:0] SRC_OFF_RETAIN = 12'h00c;
  localparam logic [11:0] SRC_OFF_CTRL = 12'h010;

  // Cause bit positions, shared by cause, status and mask registers
  localparam int SRC_B_POR = 0;
  localparam int SRC_B_PIN = 1;
  localparam int SRC_B_WAKE = 2;
  localparam int SRC_B_SOFT = 3;
  localparam int SRC_B_LOCKUP = 4;
  localparam int SRC_B_WDOG = 5;
  localparam int SRC_B_BROWN = 6;
  localparam int SRC_NCAUSE = 7;

  // Target bit positions in the target vector
  localparam int SRC_T_CPU = 0;
  localparam int SRC_T_MODEM = 1;
  localparam int SRC_T_DEBUG = 2;
  localparam int SRC_T_DBGPORT = 3;
  localparam int SRC_T_RAM_NRET = 4;
  localparam int SRC_T_RAM_RET = 5;
  localparam int SRC_T_WDOG = 6;
  localparam int SRC_T_CAUSE = 7;
  localparam int SRC_T_PERIPH = 8;
  localparam int SRC_T_GPIO_SPU = 9;
  localparam int SRC_T_WAITST = 10;
  localparam int SRC_T_RDDELAY = 11;
  localparam int SRC_T_REGOSC = 12;
  localparam int SRC_T_GPRET = 13;
  localparam int SRC_NTGT = 14;

  // Reset values
  // Power-on is the cause recorded while presetn holds
  localparam logic [6:0] SRC_RST_CAUSE = 7'h01;
  localparam logic [6:0] SRC_RST_MASK = 7'h00;
  localparam logic [7:0] SRC_RST_RETAIN = 8'h00;
  localparam logic [13:0] SRC_ALL_TARGETS = 14'h3fff;

  // Least length of an issued reset pulse
  localparam int SRC_PULSE_NS = 100;
  localparam int SRC_CLK_NS = 10;
  localparam int SRC_PULSE_CYC = (SRC_PULSE_NS + SRC_CLK_NS - 1) / SRC_CLK_NS;
endpackage

//--- verilog/src_sync.sv
/*
  Three-stage synchroniser with agreement filter for one asynchronous input.
  Assumes the input may change at any time relative to pclk.
*/
`timescale 1ns/1ps
module src_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } src_sync_state_t;

  src_sync_state_t st;
  src_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Only a change seen by both later stages counts
    if (st.s2 == st.s3) begin
      next_st.out = st.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= {4{RESET_VAL}};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.out;
endmodule

//--- verilog/src_top.sv
/*
  System reset controller: collects the seven reset sources, drives one
  reset line per target, records the cause and offers an APB register file.
  Assumes presetn itself is the power-on reset of the always-on domain;
  pins and supervisor levels are asynchronous, core and watchdog inputs are
  on pclk.
*/
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [R1] Latch the cause of the latest reset in a readable cause register.
// [R2] Hold everything in reset until supply good and regulator started.
// [R3] External reset pin low generates a pin reset.
// [R4] Wake from deep off generates a reset.
// [R5] Wake in debug mode leaves debug logic and debug port alone.
// [R6] Core reset request bit generates a soft reset.
// [R7] Watchdog timeout generates a watchdog reset.
// [R8] Brownout holds the system in reset while it lasts.
// [R9] Retained state survives deep off and sources not targeting it.
// [R10] Lockup and soft reset hit only CPU and modem among main targets.
// [R11] Wake resets CPU, modem, debug, plain RAM, watchdog; spares the rest.
// [R12] Watchdog and pin reset as wake; pin also resets the debug port.
// [R13] Brownout and power-on reset everything; brownout clears the cause.
// [R14] Lockup ignored in debug mode and in deep off.
// [R15] Watchdog source ignored in deep off.
// [R16] RAM is never cleared, only flagged as possibly corrupted.
// [R17] Lockup and soft reset peripherals, GPIO, protection, wait states.
// [R18] Wake resets peripherals and wait states only among settings.
// [R19] Watchdog and pin also reset regulators; brownout and power-on all.
module src_top
  import src_pkg::*;
#(
  parameter int PULSE_CYC = SRC_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_good,
  input wire logic regulator_started,
  input wire logic brownout,
  input wire logic external_reset_pin_n,
  input wire logic wake_from_off,
  input wire logic debug_mode,
  input wire logic deep_off,
  input wire logic system_reset_request_bit,
  input wire logic core_lockup,
  input wire logic watchdog_timeout,
  output logic [SRC_NTGT-1:0] target_rst,
  output logic ram_maybe_corrupt,
  output logic irq
);
  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin
      $error("PULSE_CYC out of range");
    end
  end

  typedef enum logic [1:0] {
    SRC_ST_POWERUP = 2'b00,
    SRC_ST_RUN = 2'b01,
    SRC_ST_PULSE = 2'b10
  } src_fsm_t;

  typedef struct packed {
    src_fsm_t fsm;
    logic [7:0] cnt;
    logic [SRC_NTGT-1:0] tgt;
    logic [SRC_NCAUSE-1:0] cause;
    logic [SRC_NCAUSE-1:0] status;
    logic [SRC_NCAUSE-1:0] mask;
    logic [7:0] retain;
    logic ram_flag;
    logic wake_q;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } src_state_t;

  src_state_t st;
  src_state_t next_st;

  logic pin_n_s;
  logic sup_s;
  logic reg_s;
  logic bo_s;

  src_sync #(.RESET_VAL(1'b1)) u_sync_pin (
    .pclk(pclk), .presetn(presetn), .din(external_reset_pin_n), .dout(pin_n_s));
  src_sync #(.RESET_VAL(1'b0)) u_sync_sup (
    .pclk(pclk), .presetn(presetn), .din(supply_good), .dout(sup_s));
  src_sync #(.RESET_VAL(1'b0)) u_sync_reg (
    .pclk(pclk), .presetn(presetn), .din(regulator_started), .dout(reg_s));
  src_sync #(.RESET_VAL(1'b0)) u_sync_bo (
    .pclk(pclk), .presetn(presetn), .din(brownout), .dout(bo_s));

  logic [SRC_NTGT-1:0] tgt_soft;
  logic [SRC_NTGT-1:0] tgt_wake;
  logic [SRC_NTGT-1:0] tgt_wdog;
  logic [SRC_NTGT-1:0] tgt_pin;

  // Target masks per source
  always_comb begin
    tgt_soft = '0;
    tgt_soft[SRC_T_CPU] = 1'b1; // R10
    tgt_soft[SRC_T_MODEM] = 1'b1;
    tgt_soft[SRC_T_PERIPH] = 1'b1; // R17
    tgt_soft[SRC_T_GPIO_SPU] = 1'b1;
    tgt_soft[SRC_T_WAITST] = 1'b1;
    tgt_wake = '0;
    tgt_wake[SRC_T_CPU] = 1'b1; // R11
    tgt_wake[SRC_T_MODEM] = 1'b1;
    tgt_wake[SRC_T_DEBUG] = !debug_mode; // R5
    tgt_wake[SRC_T_RAM_NRET] = 1'b1;
    tgt_wake[SRC_T_WDOG] = 1'b1;
    tgt_wake[SRC_T_PERIPH] = 1'b1; // R18
    tgt_wake[SRC_T_WAITST] = 1'b1;
    tgt_wdog = tgt_soft | tgt_wake; // R12
    tgt_wdog[SRC_T_DEBUG] = 1'b1;
    tgt_wdog[SRC_T_REGOSC] = 1'b1; // R19
    tgt_pin = tgt_wdog;
    tgt_pin[SRC_T_DBGPORT] = 1'b1; // R12
  end

  logic wake_rise;
  logic ev_pin;
  logic ev_soft;
  logic ev_lock;
  logic ev_wdog;
  logic [SRC_NCAUSE-1:0] ev_vec;
  logic [SRC_NTGT-1:0] ev_tgt;
  logic apb_acc;
  logic apb_rd;
  logic apb_wr;

  always_comb begin
    wake_rise = wake_from_off && !st.wake_q; // R4
    ev_pin = !pin_n_s; // R3
    ev_soft = system_reset_request_bit; // R6
    ev_lock = core_lockup && !debug_mode && !deep_off; // R14
    ev_wdog = watchdog_timeout && !deep_off; // R7 R15
    ev_vec = '0;
    ev_vec[SRC_B_PIN] = ev_pin;
    ev_vec[SRC_B_WAKE] = wake_rise;
    ev_vec[SRC_B_SOFT] = ev_soft;
    ev_vec[SRC_B_LOCKUP] = ev_lock;
    ev_vec[SRC_B_WDOG] = ev_wdog;
    ev_vec[SRC_B_BROWN] = bo_s;
    ev_tgt = '0;
    if (ev_soft || ev_lock) begin
      ev_tgt = ev_tgt | tgt_soft;
    end
    if (wake_rise) begin
      ev_tgt = ev_tgt | tgt_wake;
    end
    if (ev_wdog) begin
      ev_tgt = ev_tgt | tgt_wdog;
    end
    if (ev_pin) begin
      ev_tgt = ev_tgt | tgt_pin;
    end
    apb_acc = psel && penable && !st.pready;
    apb_rd = apb_acc && !pwrite;
    apb_wr = apb_acc && pwrite;
  end

  always_comb begin
    next_st = st;
    next_st.wake_q = wake_from_off;
    next_st.pready = apb_acc;
    next_st.pslverr = 1'b0;
    // Status is sticky; new events win over the read-clear
    if (apb_rd && paddr == SRC_OFF_STATUS) begin
      next_st.status = ev_vec;
    end else begin
      next_st.status = st.status | ev_vec;
    end
    case (st.fsm)
      SRC_ST_POWERUP: begin
        next_st.tgt = SRC_ALL_TARGETS; // R2
        if (sup_s && reg_s && !bo_s) begin
          next_st.fsm = SRC_ST_RUN;
          next_st.tgt = '0;
        end
      end
      SRC_ST_RUN: begin
        if (bo_s) begin
          // Brownout behaves like power-up and clears the old cause
          next_st.fsm = SRC_ST_POWERUP; // R8
          next_st.tgt = SRC_ALL_TARGETS; // R13
          next_st.cause = '0;
          next_st.cause[SRC_B_BROWN] = 1'b1; // R1
          next_st.retain = SRC_RST_RETAIN; // R9
          next_st.ram_flag = 1'b1; // R16
        end else if (ev_tgt != '0) begin
          next_st.fsm = SRC_ST_PULSE;
          next_st.tgt = ev_tgt;
          next_st.cnt = 8'(PULSE_CYC - 1);
          next_st.cause = ev_vec; // R1
          if (ev_tgt[SRC_T_RAM_NRET]) begin
            next_st.ram_flag = 1'b1; // R16
          end
        end
      end
      SRC_ST_PULSE: begin
        // Pin and request levels stretch the pulse while they persist
        if (bo_s) begin
          next_st.fsm = SRC_ST_RUN;
        end else if (ev_pin || ev_soft) begin
          next_st.tgt = st.tgt | ev_tgt;
          next_st.cnt = 8'(PULSE_CYC - 1);
        end else if (st.cnt == 8'h00) begin
          next_st.fsm = SRC_ST_RUN;
          next_st.tgt = '0;
        end else begin
          next_st.cnt = st.cnt - 8'h01;
        end
      end
      default: begin
        next_st.fsm = SRC_ST_POWERUP;
      end
    endcase
    if (apb_wr) begin
      case (paddr)
        SRC_OFF_MASK: next_st.mask = pwdata[SRC_NCAUSE-1:0];
        SRC_OFF_RETAIN: next_st.retain = pwdata[7:0]; // R9
        SRC_OFF_CTRL: next_st.ram_flag = st.ram_flag & ~pwdata[0];
        SRC_OFF_CAUSE: next_st.cause = st.cause & ~pwdata[SRC_NCAUSE-1:0];
        default: next_st.pslverr = 1'b1;
      endcase
    end
    next_st.prdata = '0;
    if (apb_rd) begin
      case (paddr)
        SRC_OFF_CAUSE: next_st.prdata = {25'h0, st.cause}; // R1
        SRC_OFF_MASK: next_st.prdata = {25'h0, st.mask};
        SRC_OFF_STATUS: next_st.prdata = {25'h0, st.status};
        SRC_OFF_RETAIN: next_st.prdata = {24'h0, st.retain};
        SRC_OFF_CTRL: next_st.prdata = {31'h0, st.ram_flag};
        default: next_st.pslverr = 1'b1;
      endcase
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.fsm <= SRC_ST_POWERUP;
      st.tgt <= SRC_ALL_TARGETS;
      st.cause <= SRC_RST_CAUSE;
      st.mask <= SRC_RST_MASK;
      st.retain <= SRC_RST_RETAIN;
      st.ram_flag <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign target_rst = st.tgt;
  assign ram_maybe_corrupt = st.ram_flag;
  assign irq = st.irq;
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
endmodule

//--- verification/src_partner.sv
/*
  Far-side model: supply supervisor, reset pin, watchdog, core, wake.
  Assumes the bench calls its tasks right after a pclk rising edge.
*/
`timescale 1ns/1ps
module src_partner (
  input wire logic pclk,
  output logic supply_good,
  output logic regulator_started,
  output logic brownout,
  output logic external_reset_pin_n,
  output logic system_reset_request_bit,
  output logic core_lockup,
  output logic watchdog_timeout,
  output logic wake_from_off
);
  logic [5:0] act = 6'h00;
  initial begin
    supply_good = 1'b0;
    regulator_started = 1'b0;
  end
  assign brownout = act[0];
  assign external_reset_pin_n = !act[1];
  assign system_reset_request_bit = act[2];
  assign core_lockup = act[3];
  assign watchdog_timeout = act[4];
  assign wake_from_off = act[5];
  task automatic power_up();
    supply_good <= 1'b1;
    @(posedge pclk);
    regulator_started <= 1'b1;
  endtask
  // Pin idles high through its pull-up
  task automatic pulse(input int s, input int n);
    act[s] <= 1'b1;
    repeat (n) @(posedge pclk);
    act[s] <= 1'b0;
  endtask
endmodule

//--- verification/src_top_sva.sv
/*
  Checker on the ports of src_top.
  Assumes PULSE_CYC of 4 and that the bench never overlaps sources.
*/
`timescale 1ns/1ps
module src_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic supply_good,
  input wire logic brownout,
  input wire logic external_reset_pin_n,
  input wire logic wake_from_off,
  input wire logic debug_mode,
  input wire logic deep_off,
  input wire logic system_reset_request_bit,
  input wire logic core_lockup,
  input wire logic watchdog_timeout,
  input wire logic [13:0] target_rst
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic idle;
  assign idle = target_rst == 14'h0 && !brownout && external_reset_pin_n && !wake_from_off;
  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_hold;
    target_rst[0] [*4];
  endsequence
  a_apb_answer: assert property (s_req |=> pready) else $error("no answer");
  a_pready_one: assert property (pready |=> !pready) else $error("pready long");
  a_soft_mask: assert property (system_reset_request_bit && idle && !core_lockup
    && !watchdog_timeout |=> target_rst == 14'h0703) else $error("soft mask");
  a_wdog_mask: assert property (watchdog_timeout && !deep_off && idle && !core_lockup
    && !system_reset_request_bit |=> target_rst == 14'h1757) else $error("wdog mask");
  a_lockup_dbg: assert property (core_lockup && debug_mode && idle && !watchdog_timeout
    && !system_reset_request_bit |=> target_rst == 14'h0) else $error("lockup");
  a_wdog_off: assert property (watchdog_timeout && deep_off && idle && !core_lockup
    && !system_reset_request_bit |=> target_rst == 14'h0) else $error("wdog off");
  a_brown_all: assert property (brownout [*6] |-> target_rst == 14'h3fff)
    else $error("brownout");
  a_supply_hold: assert property (!supply_good [*6] |-> target_rst == 14'h3fff)
    else $error("supply");
  a_ret_ram: assert property (target_rst[5] |-> target_rst == 14'h3fff)
    else $error("retained ram");
  a_pulse_len: assert property ($rose(target_rst[0]) |-> s_hold)
    else $error("short pulse");
endmodule
bind src_top src_top_sva u_src_top_sva (.*);

//--- verification/test_system_reset_controller.sv
/*
  Bench for src_top: APB master, source scenarios, verdict.
  Assumes src_partner drives the supervisor, pin, core and wake lines.
*/
`timescale 1ns/1ps
module test_system_reset_controller;
  import src_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic debug_mode = 1'b0, deep_off = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sg, rs, bo, pin_n, req, lk, wd, wk, ram, irq;
  logic [13:0] tr;
  int fail_count = 0, n_compared = 0;
  always #5 pclk = ~pclk;
  src_partner u_src_partner (.pclk(pclk), .supply_good(sg), .regulator_started(rs),
    .brownout(bo), .external_reset_pin_n(pin_n), .system_reset_request_bit(req),
    .core_lockup(lk), .watchdog_timeout(wd), .wake_from_off(wk));
  src_top #(.PULSE_CYC(4)) u_src_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_good(sg), .regulator_started(rs),
    .brownout(bo), .external_reset_pin_n(pin_n), .wake_from_off(wk),
    .debug_mode(debug_mode), .deep_off(deep_off), .system_reset_request_bit(req),
    .core_lockup(lk), .watchdog_timeout(wd), .target_rst(tr), .ram_maybe_corrupt(ram),
    .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk(1'b0, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Fires one source and judges targets and cause; et of zero means ignored
  task automatic fire(input int s, input int n, input logic [13:0] et, input logic [6:0] ec);
    int k;
    fork u_src_partner.pulse(s, n); join_none
    k = 0;
    while (tr === 14'h0 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    chk(tr, et);
    repeat (n + 1) @(posedge pclk);
    while (tr !== 14'h0 && k < 80) begin
      @(posedge pclk);
      k++;
    end
    apb(1'b0, SRC_OFF_CAUSE, 32'h0);
    if (et !== 14'h0) chk(rd, {25'h0, ec});
  endtask
  task automatic t_power();
    repeat (8) @(posedge pclk);
    chk(tr, 14'h3fff);
    apb(1'b0, 12'h0f0, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, SRC_OFF_CAUSE, 32'h0);
    chk(rd, 32'h1);
    u_src_partner.power_up();
    repeat (12) @(posedge pclk);
    chk(tr, 14'h0);
    $display("power done");
  endtask
  task automatic t_sources();
    apb(1'b1, SRC_OFF_RETAIN, 32'ha5);
    apb(1'b1, SRC_OFF_MASK, 32'h7f);
    apb(1'b1, SRC_OFF_CTRL, 32'h1);
    fire(2, 1, 14'h0703, 7'h08);
    chk(ram, 1'b0);
    chk(irq, 1'b1);
    apb(1'b0, SRC_OFF_STATUS, 32'h0);
    chk(rd, 32'h08);
    chk(irq, 1'b0);
    apb(1'b0, SRC_OFF_RETAIN, 32'h0);
    chk(rd, 32'ha5);
    debug_mode <= 1'b1;
    fire(3, 1, 14'h0, 7'h0);
    debug_mode <= 1'b0;
    fire(3, 1, 14'h0703, 7'h10);
    deep_off <= 1'b1;
    fire(4, 1, 14'h0, 7'h0);
    deep_off <= 1'b0;
    fire(4, 1, 14'h1757, 7'h20);
    chk(ram, 1'b1);
    apb(1'b1, SRC_OFF_MASK, 32'h0);
    fire(1, 4, 14'h175f, 7'h02);
    chk(irq, 1'b0);
    debug_mode <= 1'b1;
    fire(5, 2, 14'h0553, 7'h04);
    debug_mode <= 1'b0;
    fire(5, 2, 14'h0557, 7'h04);
    apb(1'b0, SRC_OFF_RETAIN, 32'h0);
    chk(rd, 32'ha5);
    fire(0, 8, 14'h3fff, 7'h40);
    apb(1'b0, SRC_OFF_RETAIN, 32'h0);
    chk(rd, 32'h0);
    $display("sources done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_power();
    t_sources();
    wrap_up();
  end
endmodule
